// [src/power_good_tree_select.v]
// power-good mask bank for outputs 1 and 4 with register port.
// assumes rail and control-pin levels are asynchronous to clk.
`timescale 1ns/100ps
`include "pg_tree_consts.vh"
module power_good_tree_select (
  // clock and control
  input  wire       clk,
  input  wire       reset,
  input  wire       ce,
  // register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata_r,
  // rail power-good levels
  input  wire [5:0] step_down_controller_good,
  input  wire       converter_a1_good,
  input  wire       regulator_a2_good,
  input  wire       regulator_a3_good,
  input  wire       converter_b1_good,
  input  wire       converter_b2_good,
  input  wire       regulator_a1_good,
  input  wire       termination_regulator_good,
  // control pin levels
  input  wire       control_input_1,
  input  wire       control_input_2,
  input  wire       control_input_4,
  input  wire       control_input_5,
  // otp selection of shared slot: 0 converter b2, 1 regulator a1
  input  wire       otp_shared_slot_sel,
  // aggregated outputs
  output wire       power_good_output_1,
  output wire       power_good_output_4
);
  // positions of each level in the synchroniser word
  localparam SI_CTRL1  = 0;
  localparam SI_CTRL2  = 1;
  localparam SI_CTRL3  = 2;
  localparam SI_CTRL4  = 3;
  localparam SI_CTRL5  = 4;
  localparam SI_CTRL6  = 5;
  localparam SI_CONVA1 = 6;
  localparam SI_REGA2  = 7;
  localparam SI_REGA3  = 8;
  localparam SI_CONVB1 = 9;
  localparam SI_CONVB2 = 10;
  localparam SI_REGA1  = 11;
  localparam SI_TERM   = 12;
  localparam SI_CIN1   = 13;
  localparam SI_CIN2   = 14;
  localparam SI_CIN4   = 15;
  localparam SI_CIN5   = 16;
  localparam SI_OTP    = 17;
  localparam SYNC_W    = 18;
  localparam NCTRL     = 6;
  localparam MASK_W    = 8;

  // mask registers and their next values
  reg  [MASK_W-1:0]   pg_out1_rail_mask_b_r;
  reg  [MASK_W-1:0]   pg_out4_rail_mask_a_r;
  reg  [MASK_W-1:0]   pg_out4_rail_mask_b_r;
  reg  [MASK_W-1:0]   pg_out1_rail_mask_b_nxt;
  reg  [MASK_W-1:0]   pg_out4_rail_mask_a_nxt;
  reg  [MASK_W-1:0]   pg_out4_rail_mask_b_nxt;
  reg  [MASK_W-1:0]   rdata_nxt;

  // two-stage synchroniser
  reg  [SYNC_W-1:0]   sync1_r;
  reg  [SYNC_W-1:0]   sync2_r;
  wire [SYNC_W-1:0]   raw_in;

  // synchronised rail levels
  wire [NCTRL-1:0]    ctrl_good_s;
  wire                conv_a1_good_s;
  wire                reg_a2_good_s;
  wire                reg_a3_good_s;
  wire                conv_b1_good_s;
  wire                conv_b2_good_s;
  wire                reg_a1_good_s;
  wire                term_good_s;

  // synchronised pin levels
  wire                cin1_s;
  wire                cin2_s;
  wire                cin4_s;
  wire                cin5_s;
  wire                otp_sel_s;

  // tree inputs
  wire                shared_good;
  wire [MASK_W-1:0]   good_a;
  wire [MASK_W-1:0]   good_b;
  wire [2*MASK_W-1:0] good_4;
  wire [2*MASK_W-1:0] excl_4;

  // register decode
  wire                hit_out1_b;
  wire                hit_out4_a;
  wire                hit_out4_b;
  wire                we_out1_b;
  wire                we_out4_a;
  wire                we_out4_b;

  function sel;
    input [7:0] a;
    input [7:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  // next value of one mask register
  function [7:0] mask_next;
    input [7:0] cur;
    input [7:0] d;
    input       we;
    begin
      if (we) begin
        mask_next = d;
      end else begin
        mask_next = cur;
      end
    end
  endfunction

  // shared slot source: 0 converter b2, 1 regulator a1
  function shared_pick;
    input otp_sel;
    input b2_good;
    input a1_good;
    begin
      if (otp_sel) begin
        shared_pick = a1_good;
      end else begin
        shared_pick = b2_good;
      end
    end
  endfunction

  // a pin change reaches an output on the third edge;
  // a mask write reaches it on the edge after it lands.

  // gather the asynchronous rail levels
  assign raw_in[SI_CTRL1 +: NCTRL] = step_down_controller_good;
  assign raw_in[SI_CONVA1]         = converter_a1_good;
  assign raw_in[SI_REGA2]          = regulator_a2_good;
  assign raw_in[SI_REGA3]          = regulator_a3_good;
  assign raw_in[SI_CONVB1]         = converter_b1_good;
  assign raw_in[SI_CONVB2]         = converter_b2_good;
  assign raw_in[SI_REGA1]          = regulator_a1_good;
  assign raw_in[SI_TERM]           = termination_regulator_good;

  // gather the asynchronous pin levels
  assign raw_in[SI_CIN1]           = control_input_1;
  assign raw_in[SI_CIN2]           = control_input_2;
  assign raw_in[SI_CIN4]           = control_input_4;
  assign raw_in[SI_CIN5]           = control_input_5;
  assign raw_in[SI_OTP]            = otp_shared_slot_sel;

  // only the second stage reads the first
  always @(posedge clk) begin
    if (reset) begin
      sync1_r <= {SYNC_W{1'b0}};
      sync2_r <= {SYNC_W{1'b0}};
    end else if (ce) begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // synchronised rail levels by name
  assign ctrl_good_s    = sync2_r[SI_CTRL1 +: NCTRL];
  assign conv_a1_good_s = sync2_r[SI_CONVA1];
  assign reg_a2_good_s  = sync2_r[SI_REGA2];
  assign reg_a3_good_s  = sync2_r[SI_REGA3];
  assign conv_b1_good_s = sync2_r[SI_CONVB1];
  assign conv_b2_good_s = sync2_r[SI_CONVB2];
  assign reg_a1_good_s  = sync2_r[SI_REGA1];
  assign term_good_s    = sync2_r[SI_TERM];

  // synchronised pin levels by name
  assign cin1_s         = sync2_r[SI_CIN1];
  assign cin2_s         = sync2_r[SI_CIN2];
  assign cin4_s         = sync2_r[SI_CIN4];
  assign cin5_s         = sync2_r[SI_CIN5];
  assign otp_sel_s      = sync2_r[SI_OTP];

  // shared slot source picked by otp, not by a register
  assign shared_good = shared_pick(otp_sel_s, conv_b2_good_s,
                                   reg_a1_good_s); // [R3]

  // mask b layout, same for out1 and out4
  assign good_b[`PG_B_CIN5]   = cin5_s;         // [R1] [R6]
  assign good_b[`PG_B_CIN4]   = cin4_s;         // [R1] [R6]
  assign good_b[`PG_B_CIN2]   = cin2_s;         // [R1] [R6]
  assign good_b[`PG_B_CIN1]   = cin1_s;         // [R1] [R6]
  assign good_b[`PG_B_TERM]   = term_good_s;    // [R2] [R7]
  assign good_b[`PG_B_SHARED] = shared_good;    // [R2] [R3] [R7]
  assign good_b[`PG_B_CONVB1] = conv_b1_good_s; // [R2] [R7]
  assign good_b[`PG_B_REGA3]  = reg_a3_good_s;  // [R2] [R7]

  // mask a layout: regulator a2, converter a1, controllers 6..1
  assign good_a[`PG_A_REGA2]  = reg_a2_good_s;  // [R4]
  assign good_a[`PG_A_CONVA1] = conv_a1_good_s; // [R4]
  assign good_a[`PG_A_CTRL6]  = ctrl_good_s[5]; // [R5]
  assign good_a[`PG_A_CTRL5]  = ctrl_good_s[4]; // [R5]
  assign good_a[`PG_A_CTRL4]  = ctrl_good_s[3]; // [R5]
  assign good_a[`PG_A_CTRL3]  = ctrl_good_s[2]; // [R5]
  assign good_a[`PG_A_CTRL2]  = ctrl_good_s[1]; // [R5]
  assign good_a[`PG_A_CTRL1]  = ctrl_good_s[0]; // [R5]

  // out4 tree: mask a above mask b
  assign good_4[2*MASK_W-1:MASK_W] = good_a;
  assign good_4[MASK_W-1:0]        = good_b;
  assign excl_4[2*MASK_W-1:MASK_W] = pg_out4_rail_mask_a_r;
  assign excl_4[MASK_W-1:0]        = pg_out4_rail_mask_b_r;

  // register decode
  assign hit_out1_b = sel(addr, `PG_OFS_OUT1_MASK_B); // [R9]
  assign hit_out4_a = sel(addr, `PG_OFS_OUT4_MASK_A); // [R8]
  assign hit_out4_b = sel(addr, `PG_OFS_OUT4_MASK_B); // [R8]

  // a write lands only on a mapped offset
  assign we_out1_b  = wr & hit_out1_b;
  assign we_out4_a  = wr & hit_out4_a;
  assign we_out4_b  = wr & hit_out4_b;

  // next mask values
  always @* begin
    pg_out1_rail_mask_b_nxt = mask_next(pg_out1_rail_mask_b_r, wdata,
                                        we_out1_b); // [R1] [R2]
    pg_out4_rail_mask_a_nxt = mask_next(pg_out4_rail_mask_a_r, wdata,
                                        we_out4_a); // [R8]
    pg_out4_rail_mask_b_nxt = mask_next(pg_out4_rail_mask_b_r, wdata,
                                        we_out4_b); // [R8]
  end

  // mask registers
  always @(posedge clk) begin
    if (reset) begin
      pg_out1_rail_mask_b_r <= `PG_MASK_RESET;
      pg_out4_rail_mask_a_r <= `PG_MASK_RESET;
      pg_out4_rail_mask_b_r <= `PG_MASK_RESET;
    end else if (ce) begin
      pg_out1_rail_mask_b_r <= pg_out1_rail_mask_b_nxt;
      pg_out4_rail_mask_a_r <= pg_out4_rail_mask_a_nxt;
      pg_out4_rail_mask_b_r <= pg_out4_rail_mask_b_nxt;
    end
  end

  // read data stands one cycle after rd, zero otherwise
  always @* begin
    rdata_nxt = 8'h00;
    if (rd) begin
      if (hit_out1_b) begin
        rdata_nxt = pg_out1_rail_mask_b_r; // [R9]
      end else if (hit_out4_a) begin
        rdata_nxt = pg_out4_rail_mask_a_r; // [R8]
      end else if (hit_out4_b) begin
        rdata_nxt = pg_out4_rail_mask_b_r; // [R8]
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  // out1 tree, mask b only here
  pg_combine #(
    .WIDTH (MASK_W)
  ) u_out1 (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .good     (good_b),
    .exclude  (pg_out1_rail_mask_b_r), // [R1] [R2]
    .pg_out_r (power_good_output_1)
  );

  // out4 tree, both masks
  pg_combine #(
    .WIDTH (2*MASK_W)
  ) u_out4 (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .good     (good_4),
    .exclude  (excl_4), // [R4] [R5] [R6] [R7]
    .pg_out_r (power_good_output_4)
  );
endmodule

// [src/pg_tree_consts.vh]
// register offsets, field positions and reset values of the power-good
// mask bank; included by the mask bank and its combining tree.
// Contract
// [R1] out1 mask b bits 7..4 exclude control inputs 5,4,2,1 when set.
// [R2] out1 mask b bits 3..0 exclude termination, shared slot, b1, a3.
// [R3] shared slot carries converter b2 or regulator a1, chosen by otp.
// [R4] out4 mask a bit 7 excludes regulator a2, bit 6 converter a1.
// [R5] out4 mask a bits 5..0 exclude step-down controllers 6..1.
// [R6] out4 mask b bits 7..4 exclude control inputs 5,4,2,1 when set.
// [R7] out4 mask b bits 3..0 exclude termination, shared slot, b1, a3.
// [R8] every out4 mask bit is readable and writable by software.
// [R9] out1 mask b answers at offset A5h.
// [R10] output is good only when every included input is good.
`ifndef PG_TREE_CONSTS_VH
`define PG_TREE_CONSTS_VH
`define PG_OFS_OUT1_MASK_B 8'hA5
`define PG_OFS_OUT4_MASK_A 8'hA6
`define PG_OFS_OUT4_MASK_B 8'hA7
`define PG_MASK_RESET      8'h00
// mask b field positions
`define PG_B_CIN5   7
`define PG_B_CIN4   6
`define PG_B_CIN2   5
`define PG_B_CIN1   4
`define PG_B_TERM   3
`define PG_B_SHARED 2
`define PG_B_CONVB1 1
`define PG_B_REGA3  0
// mask a field positions
`define PG_A_REGA2  7
`define PG_A_CONVA1 6
`define PG_A_CTRL6  5
`define PG_A_CTRL5  4
`define PG_A_CTRL4  3
`define PG_A_CTRL3  2
`define PG_A_CTRL2  1
`define PG_A_CTRL1  0
`endif

// [src/pg_combine.v]
// one power-good tree: and of every input whose exclude bit is clear.
// assumes inputs already synchronised to clk.
`timescale 1ns/100ps
`include "pg_tree_consts.vh"
module pg_combine #(
  parameter WIDTH = 8
) (
  // clock and control
  input  wire             clk,
  input  wire             reset,
  input  wire             ce,
  // tree inputs
  input  wire [WIDTH-1:0] good,
  input  wire [WIDTH-1:0] exclude,
  // result
  output reg              pg_out_r
);
  always @(posedge clk) begin
    if (reset) begin
      pg_out_r <= 1'b0;
    end else if (ce) begin
      // all excluded gives good
      pg_out_r <= &(good | exclude); // [R10]
    end
  end
endmodule

// [tb/pg_tree_chk.sv]
// port checker for the power-good mask bank
// register checks only count cycles with ce high; bound to every bank
`timescale 1ns/100ps
module pg_tree_chk (
  input wire       clk,
  input wire       reset,
  input wire       ce,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata_r,
  input wire       power_good_output_1,
  input wire       power_good_output_4
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence wrd(a);
    wr && ce && addr == a ##1 rd && ce && addr == a;
  endsequence
  AST_RD_IDLE: assert property (!$past(rd) && $past(ce)
    |-> rdata_r == 8'h00)
    else $error("rdata not idle");
  AST_RB_A5: assert property (wrd(8'hA5) |=> rdata_r == $past(wdata, 2))
    else $error("A5 readback");
  AST_RB_A6: assert property (wrd(8'hA6) |=> rdata_r == $past(wdata, 2))
    else $error("A6 readback");
  AST_RB_A7: assert property (wrd(8'hA7) |=> rdata_r == $past(wdata, 2))
    else $error("A7 readback");
  AST_ISOL: assert property (wr && ce && addr == 8'hA6 ##1
    wr && ce && addr == 8'hA7 ##1 rd && ce && addr == 8'hA6
    |=> rdata_r == $past(wdata, 3))
    else $error("A6 overwritten");
  AST_UNMAP: assert property (rd && ce && (addr < 8'hA5 || addr > 8'hA7)
    |=> rdata_r == 8'h00)
    else $error("unmapped read");
  AST_WR_REFUSE: assert property (wrd(8'hA8) |=> rdata_r == 8'h00)
    else $error("unmapped write");
  AST_RSTV: assert property ($past(reset) |-> !power_good_output_1
    && !power_good_output_4)
    else $error("output after reset");
  cover property (wrd(8'hA6));
  cover property ($rose(power_good_output_4));
  cover property ($fell(power_good_output_1));
endmodule
bind power_good_tree_select pg_tree_chk u_chk (.*);

// [tb/power_good_tree_select_tb.sv]
// bench for the power-good mask bank: registers and both trees
// assumes ce held high except in t_ce and levels settle within four cycles
`timescale 1ns/100ps
module power_good_tree_select_tb;
  logic       clk, reset, ce, wr, rd, otp;
  logic [7:0] addr, wdata, ga, gb;
  wire  [7:0] rdata;
  wire        pg1, pg4;
  int         mismatches = 0, tests_run = 0, cyc = 0;
  power_good_tree_select u_dut (.clk(clk), .reset(reset), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata),
    .step_down_controller_good(ga[5:0]), .converter_a1_good(ga[6]),
    .regulator_a2_good(ga[7]), .regulator_a3_good(gb[0]),
    .converter_b1_good(gb[1]), .converter_b2_good(otp | gb[2]),
    .regulator_a1_good(!otp | gb[2]), .termination_regulator_good(gb[3]),
    .control_input_1(gb[4]), .control_input_2(gb[5]),
    .control_input_4(gb[6]), .control_input_5(gb[7]),
    .otp_shared_slot_sel(otp), .power_good_output_1(pg1),
    .power_good_output_4(pg4));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      conclude();
    end
  end
  task chk(input [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input [7:0] a, d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
  endtask
  task rd_chk(input [7:0] a, e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task settle;
    wr <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task t_regs;
    for (int k = 0; k < 3; k++) rd_chk(8'hA5 + k, 8'h00);
    wr_reg(8'hA6, 8'hC3);
    wr_reg(8'hA7, 8'h81);
    rd_chk(8'hA6, 8'hC3);
    wr_reg(8'hA7, 8'h3C);
    rd_chk(8'hA7, 8'h3C);
    wr_reg(8'hA5, 8'h5A);
    rd_chk(8'hA5, 8'h5A);
    wr_reg(8'hA6, 8'hE7);
    rd_chk(8'hA6, 8'hE7);
    wr_reg(8'hA8, 8'hFF);
    rd_chk(8'hA8, 8'h00);
    rd_chk(8'hA4, 8'h00);
    for (int k = 0; k < 3; k++) wr_reg(8'hA5 + k, 8'h00);
  endtask
  task t_trees;
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 8; i++) begin
        otp <= s[0];
        ga <= ~(8'h01 << i);
        gb <= 8'hFF;
        settle();
        chk({pg4, pg1}, 2'b01);
        wr_reg(8'hA6, 8'h01 << i);
        settle();
        chk({pg4, pg1}, 2'b11);
        wr_reg(8'hA6, 8'h00);
        ga <= 8'hFF;
        gb <= ~(8'h01 << i);
        settle();
        chk({pg4, pg1}, 2'b00);
        wr_reg(8'hA7, 8'h01 << i);
        settle();
        chk({pg4, pg1}, 2'b10);
        wr_reg(8'hA5, 8'h01 << i);
        wr_reg(8'hA7, 8'h00);
        settle();
        chk({pg4, pg1}, 2'b01);
        wr_reg(8'hA5, 8'h00);
      end
  endtask
  task t_ce;
    ga <= 8'hFF;
    gb <= 8'hFF;
    settle();
    chk({pg4, pg1}, 2'b11);
    ce <= 1'b0;
    wr_reg(8'hA6, 8'hFF);
    ga <= 8'h00;
    settle();
    chk({pg4, pg1}, 2'b11);
    ce <= 1'b1;
    rd_chk(8'hA6, 8'h00);
    settle();
    chk({pg4, pg1}, 2'b01);
    ga <= 8'hFF;
  endtask
  task t_reset;
    wr_reg(8'hA6, 8'h5A);
    wr_reg(8'hA5, 8'hA5);
    reset <= 1'b1;
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk(8'hA6, 8'h00);
    chk({pg4, pg1}, 2'b00);
    rd_chk(8'hA5, 8'h00);
    settle();
    chk({pg4, pg1}, 2'b11);
  endtask
  task conclude;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {reset, wr, rd, otp, addr, wdata, ga, gb} = {4'h9, 16'h0, 16'hFFFF};
    ce = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_trees();
    t_ce();
    t_reset();
    conclude();
  end
endmodule
